// ### core/mbc_block_comparator.sv
// Marker block comparator with classic Wishbone register slave
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`include "mbc_cfg.svh"
`default_nettype none
module mbc_block_comparator
  import mbc_pkg::*;
#(
  parameter int MEM_BYTES = `MBC_MEM_BYTES
) (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    clkEn,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output var  logic [31:0]             dat_o,
  output var  logic                    ack_o,
  input  wire logic                    blockEnable,
  input  wire logic                    scanTick,
  output var  logic                    memRe,
  output var  logic [`MBC_MEM_AW-1:0]  memAddr,
  input  wire logic [7:0]              memRdata,
  output var  logic                    matchFlag,
  output var  mbc_err_t                errFlags
);

  // ==========================================
  // Helpers
  function automatic logic [32:0] sum33(input logic [31:0] a, input logic [31:0] b);
    sum33 = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    laneMerge = res;
  endfunction

  // ==========================================
  // Registers
  logic [31:0]             ctrl_r;
  logic [31:0]             srcStart_r;
  logic [31:0]             destStart_r;
  logic [31:0]             count_r;
  logic                    ack_r;
  logic [31:0]             datO_r;
  mbc_state_t              state_r;
  logic [`MBC_MEM_AW:0]    idx_r;
  logic [7:0]              srcByte_r;
  logic                    allEq_r;
  logic                    memRe_r;
  logic [`MBC_MEM_AW-1:0]  memAddr_r;
  logic                    match_r;
  mbc_err_t                err_r;

  logic                    busWrite;
  logic                    gateOn;
  logic                    runAllowed;
  logic                    anyErr;
  logic [32:0]             srcEnd;
  logic [32:0]             dstEnd;
  mbc_err_t                errNow;
  logic                    lastByte;
  logic [31:0]             statusWord;

  assign busWrite = cyc_i && stb_i && we_i && ack_r;
  assign gateOn = ctrl_r[`MBC_CTRL_GATE];
  // Enable only matters when gating is configured
  assign runAllowed = !gateOn || blockEnable;

  // ==========================================
  // Live parameter checks, never gated by enable
  // Sums are 33 bits so a huge offset cannot wrap back into range
  assign srcEnd = sum33(srcStart_r, count_r);
  assign dstEnd = sum33(destStart_r, count_r);
  always_comb begin
    errNow.countOverrunError = (srcEnd > 33'(MEM_BYTES)) || (dstEnd > 33'(MEM_BYTES));
    errNow.addressRangeError = (srcStart_r >= 32'(MEM_BYTES)) || (destStart_r >= 32'(MEM_BYTES))
                               || (count_r == 32'h0000_0000);
    errNow.overlapError      = (count_r != 32'h0000_0000)
                               && ({1'b0, srcStart_r} < dstEnd)
                               && ({1'b0, destStart_r} < srcEnd);
  end
  assign anyErr = errNow.countOverrunError || errNow.overlapError || errNow.addressRangeError;

  // Error outputs refreshed every clock-enabled cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      err_r <= '0;
    end else if (clkEn) begin
      err_r <= errNow;
    end
  end

  // ==========================================
  // Wishbone slave: one wait state, ack drops after one cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else if (clkEn) begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end

  // Status word built from live state
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`MBC_ST_MATCH] = match_r;
    statusWord[`MBC_ST_OVR]   = err_r.countOverrunError;
    statusWord[`MBC_ST_OVL]   = err_r.overlapError;
    statusWord[`MBC_ST_RNG]   = err_r.addressRangeError;
    statusWord[`MBC_ST_BUSY]  = (state_r != MBC_IDLE);
  end

  // Read data prepared together with ack; unmapped reads as zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      datO_r <= 32'h0000_0000;
    end else if (clkEn) begin
      if (adr_i == `MBC_ADR_CTRL) begin
        datO_r <= ctrl_r;
      end else if (adr_i == `MBC_ADR_SRC) begin
        datO_r <= srcStart_r;
      end else if (adr_i == `MBC_ADR_DST) begin
        datO_r <= destStart_r;
      end else if (adr_i == `MBC_ADR_COUNT) begin
        datO_r <= count_r;
      end else if (adr_i == `MBC_ADR_STATUS) begin
        datO_r <= statusWord;
      end else begin
        datO_r <= 32'h0000_0000;
      end
    end
  end

  // Writes land on the edge where the master sees ack
  // Start offsets are read live, so operand changes apply from the next byte fetch, even mid-scan
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r      <= `MBC_CTRL_RST;
      srcStart_r  <= 32'h0000_0000;
      destStart_r <= 32'h0000_0000;
      count_r     <= 32'h0000_0000;
    end else if (clkEn && busWrite) begin
      if (adr_i == `MBC_ADR_CTRL) begin
        ctrl_r <= laneMerge(ctrl_r, dat_i, sel_i) & 32'h0000_0001;
      end else if (adr_i == `MBC_ADR_SRC) begin
        srcStart_r <= laneMerge(srcStart_r, dat_i, sel_i);
      end else if (adr_i == `MBC_ADR_DST) begin
        destStart_r <= laneMerge(destStart_r, dat_i, sel_i);
      end else if (adr_i == `MBC_ADR_COUNT) begin
        count_r <= laneMerge(count_r, dat_i, sel_i);
      end
    end
  end

  // ==========================================
  // Compare sequencer: three cycles per byte pair
  // Memory returns data the cycle after memRe is high
  assign lastByte = (32'(idx_r) + 32'h0000_0001) >= count_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r   <= MBC_IDLE;
      idx_r     <= '0;
      srcByte_r <= 8'h00;
      allEq_r   <= 1'b0;
      memRe_r   <= 1'b0;
      memAddr_r <= '0;
    end else if (clkEn) begin
      case (state_r)
        MBC_IDLE: begin
          memRe_r <= 1'b0;
          // A bad parameter set never starts a fetch
          if (scanTick && runAllowed && !anyErr) begin
            state_r   <= MBC_FETCH_SRC;
            idx_r     <= '0;
            allEq_r   <= 1'b1;
            memRe_r   <= 1'b1;
            // Offset zero is the first marker byte
            memAddr_r <= srcStart_r[`MBC_MEM_AW-1:0];
          end
        end
        MBC_FETCH_SRC: begin
          state_r   <= MBC_FETCH_DST;
          memRe_r   <= 1'b1;
          memAddr_r <= `MBC_MEM_AW'(sum33(destStart_r, 32'(idx_r)));
        end
        MBC_FETCH_DST: begin
          state_r   <= MBC_CHECK;
          memRe_r   <= 1'b0;
          srcByte_r <= memRdata;
        end
        MBC_CHECK: begin
          if (memRdata != srcByte_r) begin
            allEq_r <= 1'b0;
          end
          // Early exit on the first mismatch saves scan time
          if (lastByte || (memRdata != srcByte_r)) begin
            state_r <= MBC_IDLE;
          end else begin
            state_r   <= MBC_FETCH_SRC;
            idx_r     <= idx_r + 1'b1;
            memRe_r   <= 1'b1;
            memAddr_r <= `MBC_MEM_AW'(sum33(srcStart_r, 32'(idx_r) + 32'h0000_0001));
          end
        end
        default: begin
          state_r <= MBC_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Match result; cleared at once by any live error
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      match_r <= 1'b0;
    end else if (clkEn) begin
      if (anyErr) begin
        match_r <= 1'b0;
      end else if (state_r == MBC_CHECK && (lastByte || memRdata != srcByte_r)) begin
        match_r <= allEq_r && (memRdata == srcByte_r);
      end
    end
  end

  assign dat_o     = datO_r;
  assign ack_o     = ack_r;
  assign memRe     = memRe_r;
  assign memAddr   = memAddr_r;
  assign matchFlag = match_r;
  assign errFlags  = err_r;

  // ==========================================
  // Checks
  logic busy;
  assign busy = (state_r != MBC_IDLE);

  property p_match_no_err;
    @(posedge clock) disable iff (!nrst)
    $rose(matchFlag) |-> !$past(anyErr);
  endproperty
  a_match_no_err: assert property (p_match_no_err) else $error("match rose with error");

  property p_overrun;
    @(posedge clock) disable iff (!nrst)
    $past(clkEn) && $past(srcEnd > 33'(MEM_BYTES)) |-> errFlags.countOverrunError;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_zero_count;
    @(posedge clock) disable iff (!nrst)
    // Sampled reset in the antecedent: the flags lag one edge behind release
    (nrst && count_r == 32'h0000_0000 && clkEn) [*2] |-> errFlags.addressRangeError;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count not flagged");

  property p_overlap;
    @(posedge clock) disable iff (!nrst)
    (srcStart_r == destStart_r && count_r != 32'h0000_0000 && clkEn) [*2] |-> errFlags.overlapError;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap not flagged");

  property p_gated_off;
    @(posedge clock) disable iff (!nrst)
    !busy && clkEn && gateOn && !blockEnable |=> !busy;
  endproperty
  a_gated_off: assert property (p_gated_off) else $error("started while disabled");

  property p_ungated_run;
    @(posedge clock) disable iff (!nrst)
    !busy && clkEn && !gateOn && scanTick && !anyErr |=> busy;
  endproperty
  a_ungated_run: assert property (p_ungated_run) else $error("enable not ignored");

  sequence s_start;
    $rose(busy) && clkEn;
  endsequence
  sequence s_dst_fetch;
    memRe && memAddr == destStart_r[`MBC_MEM_AW-1:0];
  endsequence

  property p_src_first;
    @(posedge clock) disable iff (!nrst)
    $rose(busy) |-> memRe && memAddr == srcStart_r[`MBC_MEM_AW-1:0];
  endproperty
  a_src_first: assert property (p_src_first) else $error("wrong source address");

  property p_dst_next;
    @(posedge clock) disable iff (!nrst)
    s_start |=> s_dst_fetch;
  endproperty
  a_dst_next: assert property (p_dst_next) else $error("wrong destination address");

endmodule // mbc_block_comparator
`default_nettype wire

// ### core/mbc_cfg.svh
// Constants for the marker block comparator
`ifndef MBC_CFG_SVH
`define MBC_CFG_SVH
// ==========================================
// Memory geometry
`define MBC_MEM_BYTES   1024
`define MBC_MEM_AW      10
// ==========================================
// Register word offsets (byte addresses)
`define MBC_ADR_CTRL    8'h00
`define MBC_ADR_SRC     8'h04
`define MBC_ADR_DST     8'h08
`define MBC_ADR_COUNT   8'h0c
`define MBC_ADR_STATUS  8'h10
// ==========================================
// Field positions and reset values
`define MBC_CTRL_GATE   0
`define MBC_CTRL_RST    32'h0000_0001
`define MBC_ST_MATCH    0
`define MBC_ST_OVR      1
`define MBC_ST_OVL      2
`define MBC_ST_RNG      3
`define MBC_ST_BUSY     4
`endif

// ### core/mbc_pkg.sv
// Types shared by the marker block comparator
package mbc_pkg;
  // Compare sequencer states
  typedef enum logic [1:0] {
    MBC_IDLE,
    MBC_FETCH_SRC,
    MBC_FETCH_DST,
    MBC_CHECK
  } mbc_state_t;

  // The three live parameter error flags
  typedef struct packed {
    logic countOverrunError;
    logic overlapError;
    logic addressRangeError;
  } mbc_err_t;
endpackage

// ### dv/mbc_marker_mem.sv
// Marker memory model for the block comparator bench
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Byte memory with one-cycle read latency
module mbc_marker_mem (
  input  wire logic       clock,
  input  wire logic       memRe,
  input  wire logic [9:0] memAddr,
  output var  logic [7:0] memRdata
);
  logic [7:0] mem [0:1023];
  // Byte i holds i mod 256, so ranges 256 apart are equal
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = i[7:0];
  end
  // Idle cycles show the inverse so a stale byte never passes
  always @(posedge clock) begin
    if (memRe) memRdata <= mem[memAddr];
    else memRdata <= ~memRdata;
  end
endmodule // mbc_marker_mem
`default_nettype wire

// ### dv/test_mbc_block_comparator.sv
// Self-checking bench for the marker block comparator
`timescale 1ns/1ns
`include "mbc_cfg.svh"
`default_nettype none
module test_mbc_block_comparator;
  import mbc_pkg::*;
  typedef struct packed {
    logic [31:0] s, d, c;
    logic        m;
    logic [2:0]  e, k;
  } mbc_row_t;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic        ack, memRe, matchFlag;
  logic        blockEnable = 1'b1;
  logic        clkEn = 1'b1;
  logic        scanTick = 1'b0;
  logic [9:0]  memAddr;
  logic [7:0]  memRdata;
  mbc_err_t    errFlags;
  int          errCount = 0;
  int          nCompared = 0;
  // Source, dest, count, match, errors, error mask
  mbc_row_t rows [10] = '{
    '{32'd10, 32'd266, 32'd4, 1'b1, 3'b000, 3'b111},
    '{32'd342, (32'd300 - 1) * 2, 32'd192, 1'b1, 3'b000, 3'b111},
    '{32'd0, (32'd193 - 1) * 4, 32'd192, 1'b1, 3'b000, 3'b111},
    '{32'd10, (32'd96 - 1) * 4, 32'd4, 1'b0, 3'b000, 3'b111},
    '{32'd1023, 32'd767, 32'd1, 1'b1, 3'b000, 3'b111},
    '{32'd50, 32'd50, 32'd8, 1'b0, 3'b010, 3'b111},
    '{32'd1000, 32'd100, 32'd30, 1'b0, 3'b100, 3'b100},
    '{32'd0, 32'd100, 32'd150, 1'b0, 3'b010, 3'b111},
    '{32'd1024, 32'd0, 32'd4, 1'b0, 3'b001, 3'b001},
    '{32'd10, 32'd266, 32'd0, 1'b0, 3'b001, 3'b111}
  };

  always #2 clock = ~clock;

  mbc_block_comparator dut (
    .clock(clock), .nrst(nrst), .clkEn(clkEn), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .blockEnable(blockEnable), .scanTick(scanTick),
    .memRe(memRe), .memAddr(memAddr), .memRdata(memRdata),
    .matchFlag(matchFlag), .errFlags(errFlags)
  );
  mbc_marker_mem mem0 (
    .clock(clock), .memRe(memRe), .memAddr(memAddr), .memRdata(memRdata)
  );

  // ==========================================
  // Shared compare and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until ack is sampled, then releases for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    check(ack, 1'b1, "ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
  endtask

  // Loads both starts and count, fires one scan, polls busy
  task automatic scan(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
    int n;
    n = 0;
    wb(1'b1, `MBC_ADR_SRC, s);
    wb(1'b1, `MBC_ADR_DST, d);
    wb(1'b1, `MBC_ADR_COUNT, c);
    scanTick <= 1'b1;
    @(posedge clock);
    scanTick <= 1'b0;
    do begin
      wb(1'b0, `MBC_ADR_STATUS, 32'h0);
      n++;
    end while (q[4] === 1'b1 && n < 400);
    check(q[4], 1'b0, "busy");
  endtask

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    check({ack, memRe, matchFlag}, 3'b000, "reset outs");
    check({errFlags, memAddr}, 32'h0000_0000, "reset state");
    check(rdat, 32'h0000_0000, "reset data");
    nrst <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    check(errFlags, 3'b001, "zero count");
    wb(1'b0, `MBC_ADR_CTRL, 32'h0);
    check(q, `MBC_CTRL_RST, "ctrl reset");
    wb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0, "unmapped");
    // Byte lane enables merge into the held word
    wb(1'b1, `MBC_ADR_SRC, 32'h1234_5678);
    sel <= 4'h1;
    wb(1'b1, `MBC_ADR_SRC, 32'hffff_ff9a);
    sel <= 4'hf;
    wb(1'b0, `MBC_ADR_SRC, 32'h0);
    check(q, 32'h1234_569a, "lane merge");
    foreach (rows[i]) begin
      scan(rows[i].s, rows[i].d, rows[i].c);
      check(matchFlag, rows[i].m, "match");
      check(errFlags & rows[i].k, rows[i].e, "errors");
    end
    // A differing byte just past the range must not matter
    mem0.mem[14] = 8'hff;
    scan(32'd10, 32'd266, 32'd4);
    check(matchFlag, 1'b1, "count edge");
    scan(32'd10, 32'd266, 32'd5);
    check(matchFlag, 1'b0, "count plus one");
    scan(32'd10, 32'd266, 32'd4);
    // Gated and disabled: match holds, errors still live
    blockEnable <= 1'b0;
    scan(32'd10, 32'd380, 32'd4);
    check(matchFlag, 1'b1, "disabled hold");
    scan(32'd10, 32'd266, 32'd0);
    check(errFlags, 3'b001, "live error");
    wb(1'b1, `MBC_ADR_CTRL, 32'h0);
    scan(32'd10, 32'd266, 32'd4);
    check(matchFlag, 1'b1, "gate off runs");
    scan(32'd10, 32'd380, 32'd4);
    check(matchFlag, 1'b0, "gate off diff");
    // Clock enable low freezes everything, even a valid start
    clkEn <= 1'b0;
    scanTick <= 1'b1;
    @(posedge clock);
    scanTick <= 1'b0;
    @(posedge clock);
    check(memRe, 1'b0, "frozen start");
    clkEn <= 1'b1;
    @(posedge clock);
    // Reset while the sequencer is idle clears outputs and restores register defaults
    nrst <= 1'b0;
    @(posedge clock);
    check({ack, memRe, matchFlag, errFlags}, 32'h0000_0000, "mid reset");
    nrst <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    check(errFlags, 3'b001, "reset zero count");
    wb(1'b0, `MBC_ADR_CTRL, 32'h0);
    check(q, `MBC_CTRL_RST, "ctrl after reset");
    conclude();
  end

  // Watchdog well beyond the expected run time
  initial begin
    #200000;
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule // test_mbc_block_comparator
`default_nettype wire
